// >>> rtl/mbsw_slave.sv
// Slave end: validates requests, performs preset of registers, forms replies
`default_nettype none
// How it works
// - Preset at most 60 consecutive registers
// - Master zeroes bits above 16-bit width
// - Broadcast valid only for writes 5,6,15,16
// - Preset reply echoes address, function, start, quantity
// - Good processable request gets normal reply
// - Check errors discard request silently
// - Master times out missing replies
// - Unhandleable request gets exception reply
// - Exception function code is code plus 0x80
// - Master spots exception by top bit
// - Exception data is one exception code
// - Code 01: unknown function or unconfigured
// - Code 02: start plus length past range
// - Code 03: structural fault, never value range
// - Code 04: unrecoverable failure during action
// - Code 08: record file parity error
// - Code 0a: gateway path unavailable
// - Code 0b: gateway target silent
module mbsw_slave
	import mbsw_pkg::*;
#(
	parameter int         N_REGS   = NUM_REGS,
	parameter logic [7:0] MY_ADDR  = 8'h0b
)(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Link
	mbsw_if.slave            link,
	// Device state from the surrounding application
	input  wire logic        configured,
	input  wire logic        is_gateway,
	input  wire logic        dev_fault,
	input  wire logic        prog_long,
	input  wire logic        prog_busy,
	input  wire logic        file_parity_err,
	input  wire logic        gw_no_path,
	input  wire logic        gw_no_target,
	// Holding register read port
	input  wire logic [6:0]  rd_idx,
	output logic [15:0]      rd_data,
	// Event pulses
	output logic             wr_done,
	output logic             dropped
);
	logic [15:0] regs_q [N_REGS];
	logic        bcast;
	logic        mine;
	logic        is_write;
	logic        known;
	logic [16:0] end_addr;
	logic [7:0]  exc_d;

	assign bcast    = link.req_slave == ADDR_BROADCAST;
	assign mine     = bcast || link.req_slave == MY_ADDR;
	assign is_write = link.req_func == FC_WR_COIL || link.req_func == FC_WR_REG ||
		link.req_func == FC_WR_COILS || link.req_func == FC_WR_REGS;
	assign known    = link.req_func == FC_WR_REGS || link.req_func == FC_RD_FILE;
	assign end_addr = {1'b0, link.req_start} + {1'b0, link.req_qty};

	// ========================================
	// Exception selection, first cause wins
	always_comb
	begin
		exc_d = 8'h00;
		if (!known || !configured)
			exc_d = EXC_ILL_FUNC;
		else if (prog_busy)
			exc_d = EXC_BUSY;
		else if (is_gateway && gw_no_path)
			exc_d = EXC_GW_PATH;
		else if (is_gateway && gw_no_target)
			exc_d = EXC_GW_TARGET;
		else if (link.req_func == FC_WR_REGS && (link.req_qty == 16'h0000 ||
			link.req_qty > 16'(MAX_PRESET_REGS) ||
			{8'h00, link.req_bytes} != {link.req_qty[14:0], 1'b0}))
			exc_d = EXC_ILL_VALUE;
		else if (link.req_func == FC_WR_REGS && end_addr > 17'(N_REGS))
			exc_d = EXC_ILL_ADDR;
		else if (dev_fault)
			exc_d = EXC_DEV_FAIL;
		else if (link.req_func == FC_RD_FILE && link.req_ref_type == REF_TYPE_FILE &&
			file_parity_err)
			exc_d = EXC_MEM_PARITY;
		else if (prog_long)
			exc_d = EXC_ACK;
		else if (link.req_func == FC_RD_FILE)
			exc_d = EXC_ILL_FUNC;
	end

	// ========================================
	// Holding registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			for (int i = 0; i < N_REGS; i++)
				regs_q[i] <= 16'h0000;
		else if (link.req_valid && !link.req_comm_err && mine && exc_d == 8'h00 &&
			link.req_func == FC_WR_REGS)
			for (int i = 0; i < MAX_PRESET_REGS; i++)
				if (16'(i) < link.req_qty)
					regs_q[7'(link.req_start + 16'(i))] <= link.req_data[i];
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_data <= 16'h0000;
		else
			rd_data <= (32'(rd_idx) < N_REGS) ? regs_q[rd_idx] : 16'h0000;
	end

	// ========================================
	// Response
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			link.rsp_valid <= 1'b0;
			link.rsp_slave <= 8'h00;
			link.rsp_func  <= 8'h00;
			link.rsp_start <= 16'h0000;
			link.rsp_qty   <= 16'h0000;
			link.rsp_exc   <= 8'h00;
			wr_done        <= 1'b0;
			dropped        <= 1'b0;
		end
		else
		begin
			link.rsp_valid <= 1'b0;
			wr_done        <= 1'b0;
			dropped        <= 1'b0;
			if (link.req_valid && mine)
			begin
				if (link.req_comm_err || (bcast && !is_write))
					dropped <= 1'b1;
				else
				begin
					wr_done <= exc_d == 8'h00 && link.req_func == FC_WR_REGS;
					// Broadcasts are served but never answered
					link.rsp_valid <= !bcast;
					link.rsp_slave <= link.req_slave;
					link.rsp_start <= link.req_start;
					link.rsp_qty   <= link.req_qty;
					if (exc_d != 8'h00)
					begin
						link.rsp_func <= link.req_func | FC_EXC_BIT;
						link.rsp_exc  <= exc_d;
					end
					else
					begin
						link.rsp_func <= link.req_func;
						link.rsp_exc  <= 8'h00;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/mbsw_pkg.sv
// Package: function codes, exception codes and limits shared by both ends
`default_nettype none
package mbsw_pkg;
	localparam logic [7:0] FC_WR_COIL      = 8'h05;
	localparam logic [7:0] FC_WR_REG       = 8'h06;
	localparam logic [7:0] FC_WR_COILS     = 8'h0f;
	localparam logic [7:0] FC_WR_REGS      = 8'h10;
	localparam logic [7:0] FC_RD_FILE      = 8'h14;
	localparam logic [7:0] FC_WR_FILE      = 8'h15;
	localparam logic [7:0] FC_EXC_BIT      = 8'h80;
	localparam logic [7:0] ADDR_BROADCAST  = 8'h00;
	localparam logic [7:0] REF_TYPE_FILE   = 8'h06;
	localparam logic [7:0] EXC_ILL_FUNC    = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE   = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL    = 8'h04;
	localparam logic [7:0] EXC_ACK         = 8'h05;
	localparam logic [7:0] EXC_BUSY        = 8'h06;
	localparam logic [7:0] EXC_MEM_PARITY  = 8'h08;
	localparam logic [7:0] EXC_GW_PATH     = 8'h0a;
	localparam logic [7:0] EXC_GW_TARGET   = 8'h0b;
	localparam int         MAX_PRESET_REGS = 60;
	localparam int         NUM_REGS        = 100;
	localparam int         REG_W           = 16;
	localparam int         RESP_TIMEOUT    = 1000;
endpackage
`default_nettype wire

// >>> rtl/mbsw_if.sv
// Interface: decoded request from master, response back from slave
`default_nettype none
interface mbsw_if;
	logic        req_valid;
	logic        req_comm_err;
	logic [7:0]  req_slave;
	logic [7:0]  req_func;
	logic [15:0] req_start;
	logic [15:0] req_qty;
	logic [7:0]  req_bytes;
	logic [7:0]  req_ref_type;
	logic [15:0] req_data [60];
	logic        rsp_valid;
	logic [7:0]  rsp_slave;
	logic [7:0]  rsp_func;
	logic [15:0] rsp_start;
	logic [15:0] rsp_qty;
	logic [7:0]  rsp_exc;
	modport slave  (input req_valid, req_comm_err, req_slave, req_func, req_start, req_qty,
		req_bytes, req_ref_type, req_data,
		output rsp_valid, rsp_slave, rsp_func, rsp_start, rsp_qty, rsp_exc);
	modport master (output req_valid, req_comm_err, req_slave, req_func, req_start, req_qty,
		req_bytes, req_ref_type, req_data,
		input rsp_valid, rsp_slave, rsp_func, rsp_start, rsp_qty, rsp_exc);
endinterface
`default_nettype wire

// >>> rtl/mbsw_master.sv
// Master end: issues one request, waits for reply or timeout, decodes exceptions
`default_nettype none
module mbsw_master
	import mbsw_pkg::*;
#(
	parameter int TIMEOUT_CYC = RESP_TIMEOUT
)(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Link
	mbsw_if.master           link,
	// User request
	input  wire logic        go,
	input  wire logic        go_comm_err,
	input  wire logic [7:0]  go_slave,
	input  wire logic [7:0]  go_func,
	input  wire logic [15:0] go_start,
	input  wire logic [15:0] go_qty,
	input  wire logic [7:0]  go_bytes,
	input  wire logic [7:0]  go_ref_type,
	input  wire logic [15:0] go_data [60],
	// User result
	output logic             busy,
	output logic             done,
	output logic             timed_out,
	output logic             got_exc,
	output logic [7:0]       exc_code
);
	typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} mbsw_mst_e;
	mbsw_mst_e   st_q;
	logic [15:0] tmo_q;

	// ========================================
	// Request side
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q              <= M_IDLE;
			tmo_q             <= 16'h0000;
			link.req_valid    <= 1'b0;
			link.req_comm_err <= 1'b0;
			link.req_slave    <= 8'h00;
			link.req_func     <= 8'h00;
			link.req_start    <= 16'h0000;
			link.req_qty      <= 16'h0000;
			link.req_bytes    <= 8'h00;
			link.req_ref_type <= 8'h00;
			for (int i = 0; i < MAX_PRESET_REGS; i++)
				link.req_data[i] <= 16'h0000;
		end
		else
		begin
			link.req_valid <= 1'b0;
			unique case (st_q)
				M_IDLE:
					if (go)
					begin
						link.req_valid    <= 1'b1;
						link.req_comm_err <= go_comm_err;
						link.req_slave    <= go_slave;
						link.req_func     <= go_func;
						link.req_start    <= go_start;
						link.req_qty      <= go_qty;
						link.req_bytes    <= go_bytes;
						link.req_ref_type <= go_ref_type;
						// Upper bits beyond register width are already zero at 16 bits
						link.req_data     <= go_data;
						st_q              <= M_SEND;
					end
				M_SEND:
				begin
					tmo_q <= 16'h0000;
					st_q  <= M_WAIT;
				end
				M_WAIT:
					// Every request runs a timeout; broadcast and bad frames end here
					if (link.rsp_valid || tmo_q == 16'(TIMEOUT_CYC - 1))
						st_q <= M_IDLE;
					else
						tmo_q <= tmo_q + 16'h0001;
			endcase
		end
	end

	// ========================================
	// Result side
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy      <= 1'b0;
			done      <= 1'b0;
			timed_out <= 1'b0;
			got_exc   <= 1'b0;
			exc_code  <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			busy <= (st_q == M_IDLE) ? go : !(st_q == M_WAIT &&
				(link.rsp_valid || tmo_q == 16'(TIMEOUT_CYC - 1)));
			if (st_q == M_WAIT && link.rsp_valid)
			begin
				done      <= 1'b1;
				timed_out <= 1'b0;
				// Exception recognised by the function code top bit
				got_exc   <= (link.rsp_func & FC_EXC_BIT) != 8'h00;
				exc_code  <= ((link.rsp_func & FC_EXC_BIT) != 8'h00) ? link.rsp_exc : 8'h00;
			end
			else if (st_q == M_WAIT && tmo_q == 16'(TIMEOUT_CYC - 1))
			begin
				done      <= 1'b1;
				timed_out <= 1'b1;
				got_exc   <= 1'b0;
				exc_code  <= 8'h00;
			end
		end
	end
	// Busy replies (code 06) are left to the user to retry later
endmodule
`default_nettype wire

// >>> dv/mbsw_asserts.sv
// Checker: link rules between the master and slave ends
`default_nettype none
module mbsw_asserts
	import mbsw_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// Request side
	input wire logic        req_valid,
	input wire logic        req_comm_err,
	input wire logic [7:0]  req_slave,
	input wire logic [7:0]  req_func,
	input wire logic [15:0] req_start,
	input wire logic [15:0] req_qty,
	// Reply side
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_slave,
	input wire logic [7:0]  rsp_func,
	input wire logic [15:0] rsp_start,
	input wire logic [15:0] rsp_qty,
	input wire logic [7:0]  rsp_exc
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ========================================
	// Sequences
	sequence s_own_clean;
		req_valid && !req_comm_err && req_slave == 8'h0b;
	endsequence
	sequence s_normal;
		rsp_valid && rsp_exc == 8'h00;
	endsequence
	// ========================================
	// Properties
	reply_given_a: assert property (s_own_clean |=> rsp_valid)
		else $error("no reply to clean request");
	err_silent_a: assert property (req_valid && req_comm_err |=> !rsp_valid)
		else $error("reply to corrupted request");
	bcast_silent_a: assert property (req_valid && req_slave == 8'h00 |=> !rsp_valid)
		else $error("reply to broadcast");
	reply_cause_a: assert property (rsp_valid |-> $past(req_valid))
		else $error("reply without request");
	exc_func_a: assert property (rsp_valid && rsp_exc != 8'h00 |->
		rsp_func == ($past(req_func) | 8'h80))
		else $error("exception function code wrong");
	norm_echo_a: assert property (s_normal |-> rsp_func == $past(req_func)
		&& rsp_slave == $past(req_slave) && rsp_start == $past(req_start)
		&& rsp_qty == $past(req_qty))
		else $error("normal reply does not echo request");
	norm_range_a: assert property (s_normal |-> rsp_qty != 16'h0
		&& rsp_qty <= 16'h3c && {1'b0, rsp_start} + {1'b0, rsp_qty} <= 17'h64)
		else $error("normal reply outside register range");
	exc_code_a: assert property (rsp_valid && rsp_func[7] |-> rsp_exc inside
		{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h0b})
		else $error("exception code not a known code");
endmodule
`default_nettype wire

// >>> dv/modbus_slave_write_and_exceptions_bench.sv
// Bench: both ends joined, compared with a register and exception model
`default_nettype none
module modbus_slave_write_and_exceptions_bench
	import mbsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, arst_n = 0, go = 0, ce = 0;
	logic [7:0] sl = 0, fn = 0, nb = 0, rt = 0, flg = 0, exc_code;
	logic [15:0] st = 0, qt = 0, rd_data, gd [60];
	logic [6:0] rd_idx = 0;
	logic busy, done, timed_out, got_exc, wr_done, dropped;
	int fails = 0, total_checks = 0, seed = 59636;
	int mreg [100];
	logic [7:0] fv [7] = '{8'h00, 8'h11, 8'h43, 8'h83, 8'h05, 8'h21, 8'h09};
	always #5 sys_clk = ~sys_clk;
	mbsw_if i_mbsw_if ();
	mbsw_master #(.TIMEOUT_CYC(20)) i_mbsw_master (.sys_clk(sys_clk), .arst_n(arst_n),
		.link(i_mbsw_if), .go(go), .go_comm_err(ce), .go_slave(sl), .go_func(fn),
		.go_start(st), .go_qty(qt), .go_bytes(nb), .go_ref_type(rt), .go_data(gd),
		.busy(busy), .done(done), .timed_out(timed_out), .got_exc(got_exc),
		.exc_code(exc_code));
	mbsw_slave i_mbsw_slave (.sys_clk(sys_clk), .arst_n(arst_n), .link(i_mbsw_if),
		.configured(flg[0]), .is_gateway(flg[1]), .dev_fault(flg[2]), .prog_long(flg[3]),
		.prog_busy(flg[4]), .file_parity_err(flg[5]), .gw_no_path(flg[6]),
		.gw_no_target(flg[7]), .rd_idx(rd_idx), .rd_data(rd_data), .wr_done(wr_done),
		.dropped(dropped));
	mbsw_asserts i_mbsw_asserts (.sys_clk(sys_clk), .arst_n(arst_n),
		.req_valid(i_mbsw_if.req_valid), .req_comm_err(i_mbsw_if.req_comm_err),
		.req_slave(i_mbsw_if.req_slave), .req_func(i_mbsw_if.req_func),
		.req_start(i_mbsw_if.req_start), .req_qty(i_mbsw_if.req_qty),
		.rsp_valid(i_mbsw_if.rsp_valid), .rsp_slave(i_mbsw_if.rsp_slave),
		.rsp_func(i_mbsw_if.rsp_func), .rsp_start(i_mbsw_if.rsp_start),
		.rsp_qty(i_mbsw_if.rsp_qty), .rsp_exc(i_mbsw_if.rsp_exc));
	// ========================================
	// Model and checks
	function automatic int exp_code(int f, int s, int q, int b);
		if ((f != 16 && f != 20) || !flg[0]) return 1;
		if (flg[4]) return 6;
		if (flg[1] && flg[6]) return 10;
		if (flg[1] && flg[7]) return 11;
		if (f == 16 && (q == 0 || q > 60 || b != 2 * q)) return 3;
		if (f == 16 && s + q > 100) return 2;
		if (flg[2]) return 4;
		if (f == 20 && rt == 8'h06 && flg[5]) return 8;
		if (flg[3]) return 5;
		if (f == 20) return 1;
		return 0;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic [7:0] a, f, input int s, q, b, input logic err);
		int e, n;
		bit to, wd, dp, b1;
		@(posedge sys_clk);
		go <= 1;
		ce <= err;
		sl <= a;
		fn <= f;
		st <= s[15:0];
		qt <= q[15:0];
		nb <= b[7:0];
		for (int i = 0; i < 60; i++) gd[i] <= 16'($random(seed));
		@(posedge sys_clk);
		go <= 0;
		n = 0;
		wd = 0;
		dp = 0;
		b1 = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n == 1) b1 = busy;
			if (wr_done === 1'b1) wd = 1;
			if (dropped === 1'b1) dp = 1;
		end while (done !== 1'b1 && n < 60);
		e = exp_code(f, s, q, b);
		to = err || a != 8'h0b;
		if (!err && (a == 8'h0b || a == 8'h00) && e == 0)
			for (int i = 0; i < q; i++) mreg[s + i] = gd[i];
		check(16'(n < 60), 16'h1);
		check(16'(timed_out), 16'(to));
		check(16'(b1), 16'h1);
		check(16'(busy), 16'h0);
		check(16'(wd), 16'(!err && (a == 8'h0b || a == 8'h00) && f == 8'h10 && e == 0));
		check(16'(dp), 16'((a == 8'h0b || a == 8'h00) && (err || (a == 8'h00 &&
			!(f == 8'h05 || f == 8'h06 || f == 8'h0f || f == 8'h10)))));
		if (!to)
		begin
			check(16'(got_exc), 16'(e != 0));
			check(16'(exc_code), 16'(e));
		end
		$display("test f=%h a=%h s=%0d q=%0d ended", f, a, s, q);
	endtask
	task automatic sweep();
		for (int i = 0; i < 100; i++)
		begin
			@(posedge sys_clk);
			rd_idx <= i[6:0];
			@(posedge sys_clk);
			#1;
			check(rd_data, 16'(mreg[i]));
		end
	endtask
	task automatic results();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ========================================
	// Scenarios
	initial
	begin
		#200000;
		fails++;
		results();
	end
	initial
	begin
		for (int i = 0; i < 100; i++) mreg[i] = 0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1;
		flg <= 8'h01;
		run(8'h0b, 8'h10, 96, 4, 8, 0);
		run(8'h0b, 8'h10, 96, 5, 10, 0);
		run(8'h0b, 8'h10, 0, 60, 120, 0);
		run(8'h0b, 8'h10, 0, 61, 122, 0);
		run(8'h0b, 8'h10, 0, 2, 5, 0);
		run(8'h0b, 8'h10, 0, 0, 0, 0);
		run(8'h0b, 8'h01, 0, 1, 2, 0);
		sweep();
		run(8'h00, 8'h10, 10, 3, 6, 0);
		run(8'h00, 8'h01, 20, 1, 2, 0);
		run(8'h0b, 8'h10, 30, 2, 4, 1);
		run(8'h22, 8'h10, 30, 2, 4, 0);
		sweep();
		rt <= 8'h06;
		for (int k = 0; k < 14; k++)
		begin
			@(posedge sys_clk);
			flg <= fv[k % 7];
			run(8'h0b, k < 7 ? 8'h10 : 8'h14, 40, 1, 2, 0);
		end
		sweep();
		results();
	end
endmodule
`default_nettype wire
